// ==== design/e1_port_consts.vh ====
/*
 * Register offsets, field positions, reset values and encodings of the E1
 * line port control block.
 * Assumes it is included once per compilation unit by its bare name.
 */
`ifndef E1_PORT_CONSTS_VH
`define E1_PORT_CONSTS_VH

`define OFS_CTRL 8'h00
`define OFS_FRAME 8'h04
`define OFS_CODES 8'h08
`define OFS_STATUS 8'h0C
`define OFS_IRQ_STAT 8'h10
`define OFS_IRQ_MASK 8'h14
`define OFS_TSMAP 8'h18

`define CTRL_CHAN_EN 0
`define CTRL_CLK_LSB 1
`define CTRL_LOOP_LSB 3
`define FRAME_LT_LSB 0
`define FRAME_CAS 2
`define CODES_IDLE_LSB 0
`define CODES_DATA_LSB 8
`define CODES_ABCD_LSB 16

`define CLK_ADAPTIVE 2'h0
`define CLK_LOOPBACK 2'h1
`define CLK_INTERNAL 2'h2
`define LOOP_OFF 2'h0
`define LOOP_INTERNAL 2'h1
`define LOOP_EXTERNAL 2'h2
`define LT_UNFRAMED 2'h0
`define LT_CRC4_ON 2'h1
`define LT_CRC4_OFF 2'h2
`define OPM_TRANSPARENT 2'h0
`define OPM_FRACTIONAL 2'h1
`define OPM_FRAC_CAS 2'h2

`define RST_CTRL 5'h01
`define RST_FRAME 3'h5
`define RST_IDLE 8'h7E
`define RST_DATA 8'hFF
`define RST_ABCD 4'h1
`define RST_TSMAP 32'hFFFFFFFF

`define IRQ_LOS_SET 0
`define IRQ_LOS_CLR 1
`define IRQ_LT_CHG 2

`endif

// ==== design/e1_line_port_control.v ====
/*
 * E1 line port control: configuration registers on an AXI4-Lite slave,
 * loss-of-signal qualification, transmit clock selection, loopback routing
 * of the octet streams, framer mode decode and idle code insertion.
 * Assumes the framer, line interface and packet path share clk_sys and
 * present one octet per strobe; the LOS pin and the clocks are asynchronous.
 */
// Added by the designer: the AXI4-Lite interface to the registers and the address map.
// Contract
// - Channel enabled: detect and report LOS; disabled: no LOS detection.
// - Loopback clock mode: transmit clock is the recovered receive clock.
// - Internal mode uses local clock; adaptive mode uses packet-regenerated clock.
// - Internal loopback returns network-side data onto the network transmit path.
// - Internal loopback sends unframed all-ones AIS toward the PBX.
// - Internal loopback discards data received from the PBX.
// - External loopback returns PBX data to PBX and forwards to network.
// - External loopback discards data arriving from the packet network.
// - Loopback disabled: normal traffic both directions, no looping.
// - Unframed: framer pass-through, operation mode transparent, stream unaltered.
// - CRC-4 on: CRC-4 multiframing; CAS setting picks fractional or with CAS.
// - CRC-4 off: no CRC-4 multiframe; CAS setting still picks the mode.
// - Any change of line type disables the line.
// - Insert configurable idle code, default 7E, into unused transmit timeslots.
// - Unframed: idle code, signalling, conditioning patterns have no effect.
// - CAS disabled: CAS conditioning pattern has no effect.
// - Reset defaults: channel on, adaptive clock, no loopback, CRC-4 on.
// - CAS enabled: CAS multiframe, fractional with CAS; else plain fractional.
`include "e1_port_consts.vh"
`default_nettype none

module e1_line_port_control #(
    parameter ADDR_W = 8
) (
    input wire clk_sys,
    input wire arst_n,
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire losPin,
    input wire clkRecovered,
    input wire clkLocal,
    input wire clkAdaptive,
    output wire clkTxLine,
    input wire [7:0] lineRxData,
    input wire lineRxStrobe,
    input wire [4:0] lineRxSlot,
    input wire [7:0] netRxData,
    input wire netRxStrobe,
    input wire [4:0] netRxSlot,
    output reg [7:0] lineTxData,
    output reg lineTxStrobe,
    output reg [7:0] netTxData,
    output reg netTxStrobe,
    output reg [4:0] netTxSlot,
    output wire lineEnable,
    output wire framerPassThrough,
    output wire framerCrc4,
    output wire framerCasMf,
    output wire [1:0] operationMode,
    output wire [7:0] condDataPattern,
    output wire [3:0] condAbcdPattern,
    output wire condAbcdValid,
    output wire losAlarm,
    output wire irq
);

    reg chanEn_q;
    reg [1:0] clkSel_q;
    reg [1:0] loopSel_q;
    reg [1:0] lineType_q;
    reg casEn_q;
    reg lineOn_q;
    reg [7:0] idleCode_q;
    reg [7:0] dataPat_q;
    reg [3:0] abcdPat_q;
    reg [31:0] slotMap_q;
    reg [2:0] irqStat_q;
    reg [2:0] irqMask_q;
    reg losMeta_q;
    reg losSync_q;
    reg los_q;
    reg awHeld_q;
    reg wHeld_q;
    reg [ADDR_W-1:0] awAddr_q;
    reg [31:0] wData_q;
    reg [3:0] wStrb_q;

    wire unframed = (lineType_q == `LT_UNFRAMED);
    wire loopInt = (loopSel_q == `LOOP_INTERNAL);
    wire loopExt = (loopSel_q == `LOOP_EXTERNAL);

    // A word-aligned byte offset is the decode both channels share.
    function [7:0] regSel;
        input [ADDR_W-1:0] a;
        begin
            regSel = {a[7:2], 2'b00};
        end
    endfunction

    // True when no address bit lies above the eight-bit register window;
    // reads use it so that a wide bus aliases nothing; a write only gets a slave error from it and still updates the register.
    function inWindow;
        input [ADDR_W-1:0] a;
        begin
            inWindow = (a >> 8) == {ADDR_W{1'b0}};
        end
    endfunction

    // Merges write data into a stored word under the byte strobes.
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] st;
        integer b;
        begin
            merge = old;
            for (b = 0; b < 4; b = b + 1) begin
                if (st[b]) begin
                    merge[b*8 +: 8] = nw[b*8 +: 8];
                end
            end
        end
    endfunction

    // Address and data may come in either order; each is held until both are.
    assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
    assign s_axi_wready = !wHeld_q && !s_axi_bvalid;
    wire awTake = s_axi_awvalid && s_axi_awready;
    wire wTake = s_axi_wvalid && s_axi_wready;
    wire awHave = awHeld_q || awTake;
    wire wHave = wHeld_q || wTake;
    wire doWrite = awHave && wHave;
    wire [ADDR_W-1:0] wrAddr = awHeld_q ? awAddr_q : s_axi_awaddr;
    wire [31:0] wrData = wHeld_q ? wData_q : s_axi_wdata;
    wire [3:0] wrStrb = wHeld_q ? wStrb_q : s_axi_wstrb;
    wire [7:0] wrSel = regSel(wrAddr);
    wire wrHit = inWindow(wrAddr) && (wrSel <= `OFS_TSMAP);

    wire [31:0] ctrlWord = {27'h0, loopSel_q, clkSel_q, chanEn_q};
    wire [31:0] frameWord = {29'h0, casEn_q, lineType_q};
    wire [31:0] codesWord = {12'h0, abcdPat_q, dataPat_q, idleCode_q};
    wire [31:0] ctrlNew = merge(ctrlWord, wrData, wrStrb);
    wire [31:0] frameNew = merge(frameWord, wrData, wrStrb);
    wire [31:0] codesNew = merge(codesWord, wrData, wrStrb);
    wire wrFrame = doWrite && wrSel == `OFS_FRAME;
    // Encoding 3 of the line type is not a mode, so it is not stored.
    wire ltValid = frameNew[`FRAME_LT_LSB +: 2] != 2'h3;
    wire ltChange = wrFrame && ltValid &&
        frameNew[`FRAME_LT_LSB +: 2] != lineType_q;

    // LOS pin synchroniser; only the second stage is looked at.
    // The enable gates after the second stage, so a standing loss shows
    // within one cycle once the channel is switched on.
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            losMeta_q <= 1'b0;
            losSync_q <= 1'b0;
            los_q <= 1'b0;
        end else begin
            losMeta_q <= losPin;
            losSync_q <= losMeta_q;
            los_q <= chanEn_q && losSync_q;
        end
    end
    assign losAlarm = los_q;

    // Both alarm edges are events, so software learns of a loss that has
    // already cleared again before it reads the status.
    wire [2:0] irqEvent;
    assign irqEvent[`IRQ_LOS_SET] = chanEn_q && losSync_q && !los_q;
    assign irqEvent[`IRQ_LOS_CLR] = los_q && !(chanEn_q && losSync_q);
    assign irqEvent[`IRQ_LT_CHG] = ltChange;
    wire [2:0] irqClr = (doWrite && wrSel == `OFS_IRQ_STAT && wrStrb[0]) ?
        wrData[2:0] : 3'h0;

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            {loopSel_q, clkSel_q, chanEn_q} <= `RST_CTRL;
            {casEn_q, lineType_q} <= `RST_FRAME;
            lineOn_q <= 1'b1;
            idleCode_q <= `RST_IDLE;
            dataPat_q <= `RST_DATA;
            abcdPat_q <= `RST_ABCD;
            slotMap_q <= `RST_TSMAP;
            irqStat_q <= 3'h0;
            irqMask_q <= 3'h0;
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            awAddr_q <= {ADDR_W{1'b0}};
            wData_q <= 32'h0;
            wStrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else begin
            // An event in the cycle of its clear wins; no edge is lost.
            irqStat_q <= (irqStat_q & ~irqClr) | irqEvent;
            if (awTake && !doWrite) begin
                awHeld_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
            end
            if (wTake && !doWrite) begin
                wHeld_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (doWrite) begin
                awHeld_q <= 1'b0;
                wHeld_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // Addresses past the last register get a slave error.
                s_axi_bresp <= wrHit ? 2'b00 : 2'b10;
                case (wrSel)
                    `OFS_CTRL: begin
                        chanEn_q <= ctrlNew[`CTRL_CHAN_EN];
                        clkSel_q <= ctrlNew[`CTRL_CLK_LSB +: 2];
                        loopSel_q <= ctrlNew[`CTRL_LOOP_LSB +: 2];
                        // Writing the channel enable re-arms a stopped line.
                        if (ctrlNew[`CTRL_CHAN_EN] && wrStrb[0]) begin
                            lineOn_q <= 1'b1;
                        end
                    end
                    `OFS_FRAME: begin
                        if (ltValid) begin
                            lineType_q <= frameNew[`FRAME_LT_LSB +: 2];
                        end
                        // CAS is kept while unframed and applies again later.
                        casEn_q <= frameNew[`FRAME_CAS];
                        if (ltChange) begin
                            lineOn_q <= 1'b0;
                        end
                    end
                    `OFS_CODES: begin
                        idleCode_q <= codesNew[`CODES_IDLE_LSB +: 8];
                        dataPat_q <= codesNew[`CODES_DATA_LSB +: 8];
                        abcdPat_q <= codesNew[`CODES_ABCD_LSB +: 4];
                    end
                    `OFS_IRQ_MASK: begin
                        if (wrStrb[0]) begin
                            irqMask_q <= wrData[2:0];
                        end
                    end
                    `OFS_TSMAP: begin
                        slotMap_q <= merge(slotMap_q, wrData, wrStrb);
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // A level output: it falls as soon as software clears the bit.
    assign irq = |(irqStat_q & irqMask_q);

    // Reads answer one cycle after the address is taken.
    assign s_axi_arready = !s_axi_rvalid;
    wire [7:0] rdSel = regSel(s_axi_araddr);
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'b00;
            if (!inWindow(s_axi_araddr)) begin
                s_axi_rresp <= 2'b10;
                s_axi_rdata <= 32'h0;
            end else begin
                case (rdSel)
                    `OFS_CTRL: s_axi_rdata <= ctrlWord;
                    `OFS_FRAME: s_axi_rdata <= frameWord;
                    `OFS_CODES: s_axi_rdata <= codesWord;
                    `OFS_STATUS: begin
                        s_axi_rdata <= {28'h0, operationMode, lineOn_q,
                            los_q};
                    end
                    `OFS_IRQ_STAT: s_axi_rdata <= {29'h0, irqStat_q};
                    `OFS_IRQ_MASK: s_axi_rdata <= {29'h0, irqMask_q};
                    `OFS_TSMAP: s_axi_rdata <= slotMap_q;
                    default: begin
                        s_axi_rresp <= 2'b10;
                        s_axi_rdata <= 32'h0;
                    end
                endcase
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // The clock mux is combinational; a glitch-free switch belongs to the
    // clock cell that follows, which this block does not own.
    assign clkTxLine = (clkSel_q == `CLK_LOOPBACK) ? clkRecovered :
        (clkSel_q == `CLK_INTERNAL) ? clkLocal : clkAdaptive;

    assign lineEnable = lineOn_q;
    assign framerPassThrough = unframed;
    assign framerCrc4 = (lineType_q == `LT_CRC4_ON);
    assign framerCasMf = !unframed && casEn_q;
    assign operationMode = unframed ? `OPM_TRANSPARENT :
        casEn_q ? `OPM_FRAC_CAS : `OPM_FRACTIONAL;
    // Hidden settings are forced to fixed values so that a stale register
    // cannot leak into the framer.
    assign condDataPattern = unframed ? 8'hFF : dataPat_q;
    assign condAbcdValid = !unframed && casEn_q;
    assign condAbcdPattern = condAbcdValid ? abcdPat_q : 4'h0;

    // Idle fill applies to the normal path only; a looped octet goes back
    // exactly as it came.
    wire [7:0] idleNow = unframed ? 8'h00 : idleCode_q;
    wire netSlotUsed = slotMap_q[netRxSlot];

    // Octet routing; a stopped line sends nothing either way.
    // Each output strobe stands one cycle and nothing here buffers, so the
    // framer and packet path must take the octet on that edge.
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            lineTxData <= 8'h00;
            lineTxStrobe <= 1'b0;
            netTxData <= 8'h00;
            netTxStrobe <= 1'b0;
            netTxSlot <= 5'h00;
        end else begin
            lineTxStrobe <= 1'b0;
            netTxStrobe <= 1'b0;
            if (lineOn_q && loopInt) begin
                netTxStrobe <= netRxStrobe;
                netTxData <= netRxData;
                netTxSlot <= netRxSlot;
                lineTxStrobe <= netRxStrobe;
                lineTxData <= 8'hFF;
            end else if (lineOn_q && loopExt) begin
                lineTxStrobe <= lineRxStrobe;
                lineTxData <= lineRxData;
                netTxStrobe <= lineRxStrobe;
                netTxData <= lineRxData;
                netTxSlot <= lineRxSlot;
            end else if (lineOn_q) begin
                lineTxStrobe <= netRxStrobe;
                if (unframed || netSlotUsed) begin
                    lineTxData <= netRxData;
                end else begin
                    lineTxData <= idleNow;
                end
                netTxStrobe <= lineRxStrobe;
                netTxData <= lineRxData;
                netTxSlot <= lineRxSlot;
            end
        end
    end

endmodule // e1_line_port_control

`default_nettype wire

// ==== dv/e1_line_port_control_checker.sv ====
/* Concurrent checks on the E1 port control block, bound to its top module.
   Assumes one clock domain and the active-low asynchronous reset. */
`include "e1_port_consts.vh"
`default_nettype none
module e1_line_port_control_checker (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic s_axi_arready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic losPin,
    input wire logic lineRxStrobe,
    input wire logic netRxStrobe,
    input wire logic lineTxStrobe,
    input wire logic netTxStrobe,
    input wire logic lineEnable,
    input wire logic framerPassThrough,
    input wire logic framerCrc4,
    input wire logic framerCasMf,
    input wire logic [1:0] operationMode,
    input wire logic [3:0] condAbcdPattern,
    input wire logic condAbcdValid,
    input wire logic [7:0] condDataPattern,
    input wire logic losAlarm
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);
    // The alarm trails the pin by two sync stages and one register.
    property p_los;
        losAlarm |-> $past(losPin, 3);
    endproperty
    a_los: assert property (p_los) else $error("alarm without loss");
    property p_ltdis;
        $changed(framerCrc4) || $changed(framerPassThrough)
            |-> ##[0:1] !lineEnable;
    endproperty
    a_ltdis: assert property (p_ltdis) else $error("line kept on");
    property p_unf;
        framerPassThrough |-> operationMode == `OPM_TRANSPARENT
            && !framerCrc4 && !framerCasMf && !condAbcdValid
            && condDataPattern == 8'hFF;
    endproperty
    a_unf: assert property (p_unf) else $error("unframed mode");
    property p_frm;
        !framerPassThrough |-> operationMode ==
            (framerCasMf ? `OPM_FRAC_CAS : `OPM_FRACTIONAL);
    endproperty
    a_frm: assert property (p_frm) else $error("framed mode");
    property p_abcd;
        condAbcdValid == framerCasMf
            && (condAbcdValid || condAbcdPattern == 4'h0);
    endproperty
    a_abcd: assert property (p_abcd) else $error("cas pattern");
    property p_ltx;
        lineTxStrobe |-> $past(netRxStrobe) || $past(lineRxStrobe);
    endproperty
    a_ltx: assert property (p_ltx) else $error("line tx uncaused");
    property p_ntx;
        netTxStrobe |-> $past(netRxStrobe) || $past(lineRxStrobe);
    endproperty
    a_ntx: assert property (p_ntx) else $error("net tx uncaused");
    property p_off;
        !lineEnable [*2] |-> !lineTxStrobe && !netTxStrobe;
    endproperty
    a_off: assert property (p_off) else $error("traffic when off");
    property p_bhold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
    endproperty
    a_bhold: assert property (p_bhold) else $error("bvalid dropped");
    property p_rhold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read unstable");
    property p_arref;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_arref: assert property (p_arref) else $error("read overlap");
endmodule // e1_line_port_control_checker
bind e1_line_port_control e1_line_port_control_checker u_chk (.*);
`default_nettype wire

// ==== dv/e1_pbx_model.sv ====
/* PBX end of the E1 line: sends octets, drives LOS and the recovered clock.
   Assumes the bench calls its tasks and it shares clk_sys. */
`default_nettype none
module e1_pbx_model (
    input wire logic clk_sys,
    output logic losPin,
    output logic clkRecovered,
    output logic [7:0] lineRxData,
    output logic lineRxStrobe,
    output logic [4:0] lineRxSlot
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        losPin = 1'b0;
        clkRecovered = 1'b0;
        lineRxData = 8'h00;
        lineRxStrobe = 1'b0;
        lineRxSlot = 5'h00;
    end
    always #5 clkRecovered = ~clkRecovered;
    task automatic send(input logic [7:0] d, input logic [4:0] s);
        @(posedge clk_sys);
        lineRxData <= d;
        lineRxSlot <= s;
        lineRxStrobe <= 1'b1;
        @(posedge clk_sys);
        lineRxStrobe <= 1'b0;
        // A stale octet must not look valid after the strobe.
        lineRxData <= ~d;
    endtask
    task automatic los(input logic v);
        @(posedge clk_sys);
        losPin <= v;
    endtask
endmodule // e1_pbx_model
`default_nettype wire

// ==== dv/e1_line_port_control_tb_top.sv ====
/* Self-checking bench for the E1 port control block with a PBX model.
   Assumes the block answers AXI and stream traffic as its notes state. */
`default_nettype none
module e1_line_port_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 0, arst_n = 0, clkLocal = 0, clkAdaptive = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, netRxData = 0;
    logic [31:0] s_axi_wdata = 0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, netRxStrobe = 0;
    logic [4:0] netRxSlot = 0;
    wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire logic s_axi_rvalid, losPin, clkRecovered, clkTxLine, lineRxStrobe;
    wire logic lineTxStrobe, netTxStrobe, lineEnable, framerPassThrough;
    wire logic framerCrc4, framerCasMf, condAbcdValid, losAlarm, irq;
    wire logic [1:0] s_axi_bresp, s_axi_rresp, operationMode;
    wire logic [31:0] s_axi_rdata;
    wire logic [7:0] lineRxData, lineTxData, netTxData, condDataPattern;
    wire logic [4:0] lineRxSlot, netTxSlot;
    wire logic [3:0] condAbcdPattern;
    logic [31:0] frame = 32'h5, codes = 32'h0001FF7E, tsmap, ex, sn;
    logic [15:0] lf = 16'h5D5F;
    logic le = 1'b1, losE = 1'b0;
    int cyc = 0, error_cnt = 0, cmp_count = 0;
    e1_line_port_control i_dut (.*);
    e1_pbx_model i_pbx (.*);
    always #2 clk_sys = ~clk_sys;
    always #7 clkLocal = ~clkLocal;
    always #3 clkAdaptive = ~clkAdaptive;
    function automatic logic [15:0] rnd();
        lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
        return lf;
    endfunction
    function automatic logic [1:0] opm();
        return frame[1:0] == 2'h0 ? 2'h0 : frame[2] ? 2'h2 : 2'h1;
    endfunction
    function automatic logic [31:0] stat();
        return {28'h0, opm(), le, losE};
    endfunction
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er = 2'h0,
                      input logic [3:0] st = 4'hF);
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wstrb <= st;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b1;
        @(posedge clk_sys);
        s_axi_bready <= 1'b0;
        chk("bresp", er, s_axi_bresp);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er = 2'h0);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b1;
        @(posedge clk_sys);
        s_axi_rready <= 1'b0;
        chk("rresp", er, s_axi_rresp);
        chk("rdata", e, s_axi_rdata);
    endtask
    // Random octets in random slots, once per loop mode.
    task automatic streams();
        logic [15:0] r;
        logic [7:0] d, dl;
        logic [4:0] s;
        logic net, el, en;
        for (int m = 0; m < 3; m++) begin
            wr(8'h00, 32'h1 | (m << 3));
            le = 1'b1;
            repeat (4) begin
                r = rnd();
                net = r[13];
                s = r[12:8];
                d = r[7:0];
                dl = (net && m == 0 && frame[1:0] != 2'h0 && !tsmap[s])
                    ? codes[7:0] : d;
                if (net && m == 1) dl = 8'hFF;
                el = net ? m != 2 : m == 2;
                en = net ? m == 1 : m != 1;
                if (net) begin
                    @(posedge clk_sys);
                    netRxData <= d;
                    netRxSlot <= s;
                    netRxStrobe <= 1'b1;
                    @(posedge clk_sys);
                    netRxStrobe <= 1'b0;
                    netRxData <= ~d;
                end else begin
                    i_pbx.send(d, s);
                end
                #1;
                chk("lineTxStrobe", el, lineTxStrobe);
                if (el) chk("lineTxData", dl, lineTxData);
                chk("netTxStrobe", en, netTxStrobe);
                if (en) chk("netTx", {s, d}, {netTxSlot, netTxData});
            end
        end
    endtask
    task automatic tally_and_finish();
        $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    initial begin
        logic [7:0] ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
        logic [31:0] rv [7] = '{32'h1, 32'h5, 32'h0001FF7E, 32'hA, 32'h0,
                                32'h0, 32'hFFFFFFFF};
        logic [31:0] fr [5] = '{32'h1, 32'h6, 32'h2, 32'h0, 32'h5};
        logic ul, cm;
        repeat (12) @(posedge clk_sys);
        arst_n <= 1'b1;
        foreach (ra[i]) rd(ra[i], rv[i]);
        rd(8'h1C, 32'h0, 2'h2);
        wr(8'h1C, 32'h1, 2'h2);
        $display("Test reset values done");
        for (int m = 0; m < 4; m++) begin
            wr(8'h00, 32'h1 | (m << 1));
            repeat (8) begin
                #1.7;
                ex = m == 1 ? clkRecovered : m == 2 ? clkLocal : clkAdaptive;
                chk("clkTxLine", ex, clkTxLine);
            end
        end
        $display("Test clock select done");
        codes = ({rnd(), rnd()} & 32'h000FFFFF) | 32'h00010000;
        tsmap = {rnd(), rnd()};
        wr(8'h08, codes);
        wr(8'h18, tsmap);
        rd(8'h08, codes);
        wr(8'h08, 32'h000A0055, 2'h0, 4'h1);
        codes[7:0] = 8'h55;
        rd(8'h08, codes);
        foreach (fr[i]) begin
            if (fr[i][1:0] != frame[1:0]) le = 1'b0;
            frame = fr[i];
            wr(8'h04, frame);
            #1;
            chk("lineEnable", le, lineEnable);
            rd(8'h0C, stat());
            ul = frame[1:0] == 2'h0;
            cm = !ul && frame[2];
            ex = {ul, frame[1:0] == 2'h1, cm, opm()};
            sn = {framerPassThrough, framerCrc4, framerCasMf, operationMode};
            chk("mode", ex, sn);
            ex = {cm, cm ? codes[19:16] : 4'h0, ul ? 8'hFF : codes[15:8]};
            sn = {condAbcdValid, condAbcdPattern, condDataPattern};
            chk("cond", ex, sn);
            if (!le) begin
                i_pbx.send(8'h3C, 5'h01);
                #1;
                chk("offTx", 0, {lineTxStrobe, netTxStrobe});
            end
            streams();
        end
        $display("Test framing and routing done");
        wr(8'h10, 32'h7);
        wr(8'h14, 32'h1);
        i_pbx.los(1'b1);
        repeat (3) @(posedge clk_sys);
        #1;
        losE = 1'b1;
        chk("losAlarm", losE, losAlarm);
        chk("irq", 1'b1, irq);
        rd(8'h10, 32'h1);
        rd(8'h0C, stat());
        wr(8'h10, 32'h1);
        #1;
        chk("irq", 1'b0, irq);
        i_pbx.los(1'b0);
        repeat (3) @(posedge clk_sys);
        #1;
        losE = 1'b0;
        chk("losAlarm", losE, losAlarm);
        chk("irq", 1'b0, irq);
        wr(8'h14, 32'h2);
        #1;
        chk("irq", 1'b1, irq);
        wr(8'h10, 32'h2);
        #1;
        chk("irq", 1'b0, irq);
        wr(8'h00, 32'h0);
        i_pbx.los(1'b1);
        repeat (3) @(posedge clk_sys);
        #1;
        chk("losAlarm", 1'b0, losAlarm);
        rd(8'h10, 32'h0);
        $display("Test loss of signal done");
        tally_and_finish();
    end
endmodule // e1_line_port_control_tb_top
`default_nettype wire
